// ---- include/dee_pkg.sv ----
// Constants shared by the data EEPROM sequencer and its bench.
// Assumes one 200 MHz system clock and a 32-bit Avalon-MM register port.
package dee_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_ADDR = 5'h00;
  localparam logic [4:0] OFF_DATA = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;
  localparam logic [4:0] OFF_INT = 5'h0c;
  localparam logic [4:0] OFF_MPH1 = 5'h10;
  localparam logic [4:0] OFF_MPH2 = 5'h14;
  // ee_control bit positions
  localparam int B_READ_GO = 0;
  localparam int B_READ_PERMIT = 1;
  localparam int B_STORE_GO = 2;
  localparam int B_STORE_PERMIT = 3;
  localparam int B_MODE = 4;
  localparam int B_WIPE_GO = 5;
  localparam int B_WIPE_PERMIT = 6;
  localparam int B_TSEL = 7;
  // Interrupt register bit positions
  localparam int B_GIE = 0;
  localparam int B_EE_EN = 1;
  localparam int B_MF_EN = 2;
  localparam int B_EE_FLAG = 3;
  localparam int B_MF_FLAG = 4;
  // Reset values
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] INT_RST = 5'h00;
  localparam logic [7:0] MPH_RST = 8'h00;
  // Pointer high byte value that opens the control sector
  localparam logic [7:0] SECTOR_CTRL = 8'h01;
  localparam logic [7:0] ERASED = 8'h00;
  localparam logic [3:0] LO_LAST = 4'hf;
  localparam int PAGE_BYTES = 16;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int READ_TIME_NS = 10;
  localparam int READ_CLKS = (READ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_NS = 1000;
  localparam int TICK_DIV = TICK_NS * CLK_MHZ / 1000;
  localparam int WIPE_TICKS = 3200;
  localparam int STORE_TICKS = 2200;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_READ_STEP,
    ST_WIPE,
    ST_STORE_ERASE,
    ST_STORE
  } dee_state_t;
endpackage

// ---- src/dee_sequencer.sv ----
// Data EEPROM sequencer: address, data, control, interrupt and pointer registers,
// a 128-byte array, a 16-byte page buffer and the read/erase/write timer.
// Assumes an Avalon-MM master on clk_sys and a core that reports stack_full.
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module dee_sequencer #(
  parameter int TICK_DIV = dee_pkg::TICK_DIV,
  parameter int WIPE_TICKS = dee_pkg::WIPE_TICKS,
  parameter int STORE_TICKS = dee_pkg::STORE_TICKS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stack_full,
  output logic mf_vector
);

  // Doubled counts must fit the 16-bit cycle counter
  initial begin
    if (TICK_DIV < 2 || TICK_DIV > 65535 || WIPE_TICKS < 1 || WIPE_TICKS > 32767 ||
        STORE_TICKS < 1 || STORE_TICKS > 32767) begin
      $error("dee_sequencer: timing parameter out of range");
    end
  end

  localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);
  localparam logic [15:0] WIPE_N = 16'(WIPE_TICKS - 1);
  localparam logic [15:0] WIPE_L = 16'(2 * WIPE_TICKS - 1);
  localparam logic [15:0] STORE_N = 16'(STORE_TICKS - 1);
  localparam logic [15:0] STORE_L = 16'(2 * STORE_TICKS - 1);
  localparam logic [15:0] READ_N = 16'(dee_pkg::READ_CLKS - 1);

  logic [6:0] ee_address_q;
  logic [7:0] ee_data_q;
  logic [7:0] ee_control_q;
  logic [4:0] int_q;
  logic [7:0] mem_ptr_high_one_q;
  logic [7:0] mem_ptr_high_two_q;
  logic sat_q;
  logic [7:0] page_buf_q [dee_pkg::PAGE_BYTES];
  logic [15:0] tag_q;
  logic [7:0] mem [128];
  logic wipe_prev_q;
  logic store_prev_q;
  dee_pkg::dee_state_t state_q;
  logic [15:0] cnt_q;
  logic [15:0] div_q;
  logic [7:0] rd_mux;

  logic wr_fire;
  logic [7:0] wbyte;
  logic ctrl_open;
  logic idle;
  logic page_mode;
  logic tick;
  logic timer_done;
  logic rd_fetch;
  logic rd_clear;
  logic wipe_end;
  logic store_end;
  logic pre_erase_end;
  logic data_wr;
  logic page_load;
  logic buf_clear;
  logic vec_fire;
  logic [3:0] lo_next;

  // Write strobe only at the edge where the master sees waitrequest low
  assign wr_fire = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  // Control register is hidden unless a pointer high byte selects its sector
  assign ctrl_open = (mem_ptr_high_one_q == dee_pkg::SECTOR_CTRL) |
                     (mem_ptr_high_two_q == dee_pkg::SECTOR_CTRL);
  assign idle = (state_q == dee_pkg::ST_IDLE);
  assign page_mode = ee_control_q[dee_pkg::B_MODE];
  assign tick = (div_q == DIV_LAST);
  assign timer_done = tick & (cnt_q == 16'h0000);

  // Sequencer events
  assign rd_fetch = (state_q == dee_pkg::ST_READ) && (cnt_q == 16'h0000);
  assign rd_clear = (state_q == dee_pkg::ST_READ_STEP);
  assign wipe_end = (state_q == dee_pkg::ST_WIPE) && timer_done;
  assign store_end = (state_q == dee_pkg::ST_STORE) && timer_done;
  assign pre_erase_end = (state_q == dee_pkg::ST_STORE_ERASE) && timer_done;
  assign data_wr = wr_fire && (avs_address == dee_pkg::OFF_DATA) && idle;
  assign page_load = data_wr && page_mode && !sat_q;
  assign buf_clear = (wipe_prev_q & ~ee_control_q[dee_pkg::B_WIPE_PERMIT]) |
                     (store_prev_q & ~ee_control_q[dee_pkg::B_STORE_PERMIT]);
  assign vec_fire = int_q[dee_pkg::B_GIE] & int_q[dee_pkg::B_EE_EN] &
                    int_q[dee_pkg::B_MF_EN] & int_q[dee_pkg::B_MF_FLAG] &
                    int_q[dee_pkg::B_EE_FLAG] & ~stack_full & ~mf_vector;
  // Low address bits stop at the page end instead of rolling over
  assign lo_next = (ee_address_q[3:0] == dee_pkg::LO_LAST) ?
                   dee_pkg::LO_LAST : ee_address_q[3:0] + 4'h1;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (avs_address)
      dee_pkg::OFF_ADDR: rd_mux = {1'b0, ee_address_q};
      dee_pkg::OFF_DATA: rd_mux = ee_data_q;
      dee_pkg::OFF_CTRL: rd_mux = ctrl_open ? ee_control_q : 8'h00;
      dee_pkg::OFF_INT: rd_mux = {3'h0, int_q};
      dee_pkg::OFF_MPH1: rd_mux = mem_ptr_high_one_q;
      dee_pkg::OFF_MPH2: rd_mux = mem_ptr_high_two_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Bus slave: one wait cycle, then a single-cycle answer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= {24'h00_0000, rd_mux};
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Timer prescaler; stands still while idle so each cycle starts clean
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 16'h0000;
    end else if (idle || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Sequencer; erase and write lengths counted in timer ticks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= dee_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        dee_pkg::ST_IDLE: begin
          if (ee_control_q[dee_pkg::B_READ_GO]) begin
            state_q <= dee_pkg::ST_READ;
            cnt_q <= READ_N;
          end else if (ee_control_q[dee_pkg::B_WIPE_GO]) begin
            state_q <= dee_pkg::ST_WIPE;
            cnt_q <= ee_control_q[dee_pkg::B_TSEL] ? WIPE_L : WIPE_N;
          end else if (ee_control_q[dee_pkg::B_STORE_GO]) begin
            if (page_mode) begin
              state_q <= dee_pkg::ST_STORE;
              cnt_q <= ee_control_q[dee_pkg::B_TSEL] ? STORE_L : STORE_N;
            end else begin
              state_q <= dee_pkg::ST_STORE_ERASE;
              cnt_q <= ee_control_q[dee_pkg::B_TSEL] ? WIPE_L : WIPE_N;
            end
          end
        end
        dee_pkg::ST_READ: begin
          if (cnt_q == 16'h0000) begin
            state_q <= dee_pkg::ST_READ_STEP;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        dee_pkg::ST_READ_STEP: begin
          state_q <= dee_pkg::ST_IDLE;
        end
        dee_pkg::ST_STORE_ERASE: begin
          if (timer_done) begin
            state_q <= dee_pkg::ST_STORE;
            cnt_q <= ee_control_q[dee_pkg::B_TSEL] ? STORE_L : STORE_N;
          end else if (tick) begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        dee_pkg::ST_WIPE, dee_pkg::ST_STORE: begin
          if (timer_done) begin
            state_q <= dee_pkg::ST_IDLE;
          end else if (tick) begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= dee_pkg::ST_IDLE;
      endcase
    end
  end

  // Control register; start bits accept a set only behind an earlier permit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ee_control_q <= dee_pkg::CTRL_RST;
    end else begin
      if (wr_fire && (avs_address == dee_pkg::OFF_CTRL) && ctrl_open) begin
        ee_control_q[dee_pkg::B_TSEL] <= wbyte[dee_pkg::B_TSEL];
        ee_control_q[dee_pkg::B_MODE] <= wbyte[dee_pkg::B_MODE];
        ee_control_q[dee_pkg::B_READ_PERMIT] <= wbyte[dee_pkg::B_READ_PERMIT];
        ee_control_q[dee_pkg::B_STORE_PERMIT] <= wbyte[dee_pkg::B_STORE_PERMIT];
        ee_control_q[dee_pkg::B_WIPE_PERMIT] <= wbyte[dee_pkg::B_WIPE_PERMIT];
        // Writing zero to a start bit never aborts a running cycle
        if (wbyte[dee_pkg::B_READ_GO] && ee_control_q[dee_pkg::B_READ_PERMIT]) begin
          ee_control_q[dee_pkg::B_READ_GO] <= 1'b1;
        end
        if (wbyte[dee_pkg::B_STORE_GO] && ee_control_q[dee_pkg::B_STORE_PERMIT]) begin
          ee_control_q[dee_pkg::B_STORE_GO] <= 1'b1;
        end
        if (wbyte[dee_pkg::B_WIPE_GO] && ee_control_q[dee_pkg::B_WIPE_PERMIT]) begin
          ee_control_q[dee_pkg::B_WIPE_GO] <= 1'b1;
        end
      end
      // Hardware clears come last so they win
      if (rd_clear) begin
        ee_control_q[dee_pkg::B_READ_GO] <= 1'b0;
      end
      if (wipe_end) begin
        ee_control_q[dee_pkg::B_WIPE_GO] <= 1'b0;
        ee_control_q[dee_pkg::B_WIPE_PERMIT] <= 1'b0;
      end
      if (store_end) begin
        ee_control_q[dee_pkg::B_STORE_GO] <= 1'b0;
        if (page_mode) begin
          ee_control_q[dee_pkg::B_STORE_PERMIT] <= 1'b0;
        end
      end
    end
  end

  // Permit history for falling-edge detection of the buffer clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wipe_prev_q <= 1'b0;
      store_prev_q <= 1'b0;
    end else begin
      wipe_prev_q <= ee_control_q[dee_pkg::B_WIPE_PERMIT];
      store_prev_q <= ee_control_q[dee_pkg::B_STORE_PERMIT];
    end
  end

  // Address register and page-end saturation
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ee_address_q <= dee_pkg::ADDR_RST;
      sat_q <= 1'b0;
    end else if (wr_fire && (avs_address == dee_pkg::OFF_ADDR) && idle) begin
      ee_address_q <= wbyte[6:0];
      sat_q <= 1'b0;
    end else if (page_load || (rd_fetch && page_mode)) begin
      ee_address_q <= {ee_address_q[6:4], lo_next};
      if (ee_address_q[3:0] == dee_pkg::LO_LAST) begin
        sat_q <= 1'b1;
      end
    end
  end

  // Data register: software writes and fetched bytes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ee_data_q <= dee_pkg::DATA_RST;
    end else if (rd_fetch) begin
      ee_data_q <= mem[ee_address_q];
    end else if (data_wr && !(page_mode && sat_q)) begin
      ee_data_q <= wbyte;
    end
  end

  // Page buffer with per-byte tags; tags mark what a page cycle touches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tag_q <= 16'h0000;
      for (int i = 0; i < dee_pkg::PAGE_BYTES; i++) begin
        page_buf_q[i] <= 8'h00;
      end
    end else if (buf_clear) begin
      tag_q <= 16'h0000;
      for (int i = 0; i < dee_pkg::PAGE_BYTES; i++) begin
        page_buf_q[i] <= 8'h00;
      end
    end else if (page_load) begin
      page_buf_q[ee_address_q[3:0]] <= wbyte;
      tag_q[ee_address_q[3:0]] <= 1'b1;
    end
  end

  // Array update at cycle ends; nonvolatile, so no reset
  always_ff @(posedge clk_sys) begin
    if (pre_erase_end) begin
      mem[ee_address_q] <= dee_pkg::ERASED;
    end else if (wipe_end) begin
      if (page_mode) begin
        for (int i = 0; i < dee_pkg::PAGE_BYTES; i++) begin
          if (tag_q[i]) begin
            mem[{ee_address_q[6:4], 4'(i)}] <= dee_pkg::ERASED;
          end
        end
      end else begin
        mem[ee_address_q] <= dee_pkg::ERASED;
      end
    end else if (store_end) begin
      if (page_mode) begin
        for (int i = 0; i < dee_pkg::PAGE_BYTES; i++) begin
          if (tag_q[i]) begin
            mem[{ee_address_q[6:4], 4'(i)}] <= page_buf_q[i];
          end
        end
      end else begin
        mem[ee_address_q] <= ee_data_q;
      end
    end
  end

  // Interrupt flags and enables; a cycle-end set beats any clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_q <= dee_pkg::INT_RST;
      mf_vector <= 1'b0;
    end else begin
      mf_vector <= vec_fire;
      if (wr_fire && (avs_address == dee_pkg::OFF_INT)) begin
        int_q <= wbyte[4:0];
      end
      if (vec_fire) begin
        int_q[dee_pkg::B_MF_FLAG] <= 1'b0;
        int_q[dee_pkg::B_GIE] <= 1'b0;
      end
      if (wipe_end || store_end) begin
        int_q[dee_pkg::B_EE_FLAG] <= 1'b1;
        int_q[dee_pkg::B_MF_FLAG] <= 1'b1;
      end
    end
  end

  // Pointer high bytes; zero at reset keeps the control sector closed
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_ptr_high_one_q <= dee_pkg::MPH_RST;
      mem_ptr_high_two_q <= dee_pkg::MPH_RST;
    end else if (wr_fire && (avs_address == dee_pkg::OFF_MPH1)) begin
      mem_ptr_high_one_q <= wbyte;
    end else if (wr_fire && (avs_address == dee_pkg::OFF_MPH2)) begin
      mem_ptr_high_two_q <= wbyte;
    end
  end

endmodule

// ---- tb/dee_sequencer_chk.sv ----
// Checker for the sequencer register port and the shared vector output.
// Assumes it is bound to dee_sequencer and sees that module's ports only.
`timescale 1ns/10ps
module dee_sequencer_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic stack_full,
  input wire logic mf_vector
);
  logic [7:0] ptr1_q;
  logic [7:0] ptr2_q;
  logic rd_ans;
  logic ctl_ans;
  // Read answers; read data stand where waitrequest is low
  assign rd_ans = avs_read && !avs_waitrequest;
  assign ctl_ans = rd_ans && (avs_address == dee_pkg::OFF_CTRL);
  // Shadow of the pointer high bytes, so the sector gate can be judged
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr1_q <= 8'h00;
      ptr2_q <= 8'h00;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (avs_address == dee_pkg::OFF_MPH1) ptr1_q <= avs_writedata[7:0];
      if (avs_address == dee_pkg::OFF_MPH2) ptr2_q <= avs_writedata[7:0];
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  property p_addr_top;
    rd_ans && (avs_address == dee_pkg::OFF_ADDR) |-> avs_readdata[31:7] == 25'h0000000;
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("address read shows high bits");
  property p_read_gate;
    ctl_ans |-> !(avs_readdata[dee_pkg::B_READ_GO] && !avs_readdata[dee_pkg::B_READ_PERMIT]);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read go without permit");
  property p_store_gate;
    ctl_ans |-> !(avs_readdata[dee_pkg::B_STORE_GO] && !avs_readdata[dee_pkg::B_STORE_PERMIT]);
  endproperty
  a_store_gate: assert property (p_store_gate) else $error("store go without permit");
  property p_wipe_gate;
    ctl_ans |-> !(avs_readdata[dee_pkg::B_WIPE_GO] && !avs_readdata[dee_pkg::B_WIPE_PERMIT]);
  endproperty
  a_wipe_gate: assert property (p_wipe_gate) else $error("wipe go left after permit");
  property p_ctrl_gate;
    ctl_ans && (ptr1_q != 8'h01) && (ptr2_q != 8'h01) |-> avs_readdata == 32'h00000000;
  endproperty
  a_ctrl_gate: assert property (p_ctrl_gate) else $error("control readable when closed");
  property p_vec_stack;
    mf_vector |-> !$past(stack_full);
  endproperty
  a_vec_stack: assert property (p_vec_stack) else $error("vector while stack full");
  property p_vec_pulse;
    mf_vector |=> !mf_vector;
  endproperty
  a_vec_pulse: assert property (p_vec_pulse) else $error("vector longer than a cycle");
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wait_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
endmodule
bind dee_sequencer dee_sequencer_chk dee_sequencer_chk_inst (.clk_sys(clk_sys),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .stack_full(stack_full), .mf_vector(mf_vector));

// ---- tb/tb.sv ----
// Self-checking bench for the data EEPROM sequencer over its Avalon-MM port.
// Assumes dee_pkg and the design are compiled first; the checker binds itself.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  localparam logic [4:0] AD = dee_pkg::OFF_ADDR;
  localparam logic [4:0] DT = dee_pkg::OFF_DATA;
  localparam logic [4:0] CT = dee_pkg::OFF_CTRL;
  localparam logic [4:0] IT = dee_pkg::OFF_INT;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic stack_full = 1'b1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mf_vector;
  logic [7:0] q;
  int err_total = 0;
  int checked = 0;
  int vec_seen = 0;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  // Vector pulses counted at the edge that samples them
  always @(posedge clk_sys) begin
    if (mf_vector === 1'b1) vec_seen++;
  end
  // Short tick and cycle lengths keep erase and write runs brief
  dee_sequencer #(.TICK_DIV(2), .WIPE_TICKS(3), .STORE_TICKS(2)) dee_sequencer_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .stack_full(stack_full), .mf_vector(mf_vector));
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One bus cycle; held until waitrequest is seen low, an idle edge before each
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHK(q, e)
  endtask
  // Polls control until a go bit drops; bounded, a hang ends the run
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    do begin
      xfer(CT, 1'b0, 8'h00);
      n++;
    end while (q[b] !== 1'b0 && n < 200);
    `CHK(q[b], 1'b0)
    if (n >= 200) report_and_stop();
  endtask
  task automatic store_run(input logic [7:0] mode);
    wr(CT, mode | 8'h08);
    wr(CT, mode | 8'h0c);
    wait_clear(dee_pkg::B_STORE_GO);
  endtask
  task automatic wipe_run();
    wr(CT, 8'h50);
    wr(CT, 8'h70);
    wait_clear(dee_pkg::B_WIPE_GO);
  endtask
  task automatic fill(input logic [7:0] base, input int n, input logic [7:0] d);
    wr(AD, base);
    for (int i = 0; i < n; i++) wr(DT, d + 8'(i));
  endtask
  // Page read of n bytes; the first z of them expected erased
  task automatic page_read(input logic [7:0] base, input int n, input logic [7:0] d, input int z);
    wr(AD, base);
    wr(CT, 8'h12);
    for (int i = 0; i < n; i++) begin
      wr(CT, 8'h13);
      wait_clear(dee_pkg::B_READ_GO);
      rdc(DT, (i < z) ? 8'h00 : d + 8'(i));
    end
  endtask
  task automatic byte_load(input logic [7:0] a, input logic [7:0] e);
    wr(AD, a);
    wr(CT, 8'h02);
    wr(CT, 8'h03);
    wait_clear(dee_pkg::B_READ_GO);
    rdc(DT, e);
  endtask
  // Reset values, sector gate, address width, byte lanes, unmapped place
  task automatic t_regs();
    rdc(dee_pkg::OFF_MPH1, 8'h00);
    rdc(dee_pkg::OFF_MPH2, 8'h00);
    rdc(IT, 8'h00);
    rdc(5'h18, 8'h00);
    wr(CT, 8'h10);
    wr(dee_pkg::OFF_MPH2, 8'h01);
    rdc(CT, 8'h00);
    wr(dee_pkg::OFF_MPH2, 8'h00);
    wr(dee_pkg::OFF_MPH1, 8'h01);
    wr(AD, 8'hff);
    rdc(AD, 8'h7f);
    avs_byteenable <= 4'he;
    wr(AD, 8'h05);
    avs_byteenable <= 4'hf;
    rdc(AD, 8'h7f);
  endtask
  // Byte mode: refused go bits, write with erase, read and hold
  task automatic t_byte();
    wr(AD, 8'h05);
    wr(DT, 8'ha5);
    wr(CT, 8'h04);
    rdc(CT, 8'h00);
    store_run(8'h00);
    rdc(IT, 8'h18);
    wr(CT, 8'h01);
    rdc(CT, 8'h00);
    byte_load(8'h05, 8'ha5);
    wr(DT, 8'h5a);
    store_run(8'h00);
    wr(DT, 8'h00);
    byte_load(8'h05, 8'h5a);
    rdc(AD, 8'h05);
    rdc(DT, 8'h5a);
    wr(IT, 8'h00);
  endtask
  // Page erase, page write with overrun, page read, partial erase
  task automatic t_page();
    wr(CT, 8'h10);
    fill(8'h20, 16, 8'h00);
    wipe_run();
    rdc(CT, 8'h10);
    rdc(IT, 8'h18);
    // Flags cleared so the page write end has to set them again
    wr(IT, 8'h00);
    fill(8'h20, 17, 8'h30);
    rdc(AD, 8'h2f);
    store_run(8'h10);
    rdc(CT, 8'h10);
    rdc(IT, 8'h18);
    page_read(8'h20, 16, 8'h30, 0);
    rdc(AD, 8'h2f);
    fill(8'h20, 4, 8'h00);
    wipe_run();
    page_read(8'h20, 5, 8'h30, 4);
  endtask
  // Buffer clear on permit fall, kept on permit rise
  task automatic t_buffers();
    fill(8'h24, 1, 8'h00);
    wr(CT, 8'h50);
    wr(CT, 8'h10);
    wipe_run();
    page_read(8'h24, 1, 8'h34, 0);
    wr(CT, 8'h18);
    fill(8'h20, 2, 8'h77);
    wr(CT, 8'h10);
    store_run(8'h10);
    page_read(8'h20, 2, 8'h00, 2);
    wr(CT, 8'h98);
    fill(8'h22, 1, 8'h66);
    wr(CT, 8'h9c);
    // Doubled length still runs at the third poll; a plain length has ended
    repeat (3) rdc(CT, 8'h9c);
    wait_clear(dee_pkg::B_STORE_GO);
    page_read(8'h22, 1, 8'h66, 0);
  endtask
  // Vector held off by a full stack, then taken once
  task automatic t_vector();
    wr(IT, 8'h1f);
    rdc(IT, 8'h1f);
    `CHK(vec_seen, 0)
    stack_full <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(vec_seen, 1)
    rdc(IT, 8'h0e);
    // Closed sector hides control and refuses writes to it
    wr(dee_pkg::OFF_MPH1, 8'h00);
    rdc(CT, 8'h00);
    wr(CT, 8'h00);
    wr(dee_pkg::OFF_MPH1, 8'h01);
    rdc(CT, 8'h12);
  endtask
  // Idle reset with the write permit set clears it and the pointer high bytes
  task automatic t_reset();
    wr(CT, 8'h18);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc(dee_pkg::OFF_MPH1, 8'h00);
    wr(dee_pkg::OFF_MPH1, 8'h01);
    rdc(CT, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_byte();
    t_page();
    t_buffers();
    t_vector();
    t_reset();
    report_and_stop();
  end
endmodule
